/* File: common/saths_consts.vh */
// constants for the track/hold and successive-approximation sequencer
`ifndef SATHS_CONSTS_VH
`define SATHS_CONSTS_VH
`define SATHS_RES_BITS      10
`define SATHS_CONV_CYCLES   13
`define SATHS_ACQ_EDGES     3'h4
`define SATHS_INT_ACQ_NS    1000
`define SATHS_CLK_NS        5
`define SATHS_OSC_DIV       ((`SATHS_INT_ACQ_NS + `SATHS_CLK_NS * `SATHS_ACQ_EDGES * 2 - 1) / (`SATHS_CLK_NS * `SATHS_ACQ_EDGES * 2))
`define SATHS_CB_PD1        7
`define SATHS_CB_PD0        6
`define SATHS_CB_EXTACQ     5
`define SATHS_CB_SGL        4
`define SATHS_CB_UNI        3
`define SATHS_CB_ADDR_HI    2
`define SATHS_CB_ADDR_LO    0
`define SATHS_CB_RESET      8'h00
`endif

/* File: logic/saths_sequencer.v */
// control sequencer for the track/hold stage, input multiplexer and result port
// Operation
// [RL1] write strobe rising edge starts tracking
// [RL2] external mode: next strobe rise enters hold
// [RL3] internal mode: hold on fourth clock fall
// [RL4] internal clock: hold about 1us after write
// [RL5] single-ended: channel to positive, common to negative
// [RL6] pseudo-differential: both sides from channel pair
// [RL7] capacitor on positive while acquiring, then hold
// [RL8] conversion starts by switching capacitor to negative
// [RL9] next cycle reconnects positive input to capacitor
// [RL10] successive approximation yields ten-bit result
// [RL11] result read as eight plus two bits
// [RL12] high select gives two msbs, else lsbs
// [RL13] conversion takes thirteen conversion clock cycles
// [RL14] internal mode write latches byte, starts cycle
// [RL15] channel address held stable through conversion
// [RL16] switch controls clean, no positive/negative overlap
`include "saths_consts.vh"
`default_nettype none
module saths_sequencer #(
    parameter RES_BITS = `SATHS_RES_BITS,
    parameter CONV_CYC = `SATHS_CONV_CYCLES,
    parameter OSC_DIV  = `SATHS_OSC_DIV
) (
    input  wire                clock,
    input  wire                reset_n,
    input  wire                cs_n,
    input  wire                wr_n,
    input  wire                rd_n,
    input  wire                high_byte_select,
    input  wire                conv_clk,
    input  wire [7:0]          data_in,
    input  wire                comp_out,
    output reg  [7:0]          data_out,
    output reg                 data_oe,
    output reg                 eoc_n,
    output reg                 track,
    output reg                 hold_capacitor,
    output reg                 pos_sw,
    output reg                 neg_sw,
    output reg  [2:0]          pos_chan,
    output reg  [2:0]          neg_chan,
    output reg                 neg_to_com,
    output reg                 unipolar,
    output reg  [RES_BITS-1:0] dac_code,
    output reg  [1:0]          power_mode
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and edge detection

reg [1:0] wr_s_r, cs_s_r, rd_s_r, hb_s_r, ck_s_r, cmp_s_r;
reg       wr_d_r, ck_d_r, rd_d_r;
reg [7:0] din_s1_r, din_s2_r;

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        wr_s_r   <= 2'h3;
        cs_s_r   <= 2'h3;
        rd_s_r   <= 2'h3;
        hb_s_r   <= 2'h0;
        ck_s_r   <= 2'h0;
        cmp_s_r  <= 2'h0;
        wr_d_r   <= 1'b1;
        ck_d_r   <= 1'b0;
        rd_d_r   <= 1'b1;
        din_s1_r <= 8'h00;
        din_s2_r <= 8'h00;
    end else begin
        wr_s_r   <= {wr_s_r[0], wr_n};
        cs_s_r   <= {cs_s_r[0], cs_n};
        rd_s_r   <= {rd_s_r[0], rd_n};
        hb_s_r   <= {hb_s_r[0], high_byte_select};
        ck_s_r   <= {ck_s_r[0], conv_clk};
        cmp_s_r  <= {cmp_s_r[0], comp_out};
        din_s1_r <= data_in;
        din_s2_r <= din_s1_r;
        wr_d_r   <= wr_s_r[1];
        ck_d_r   <= ck_s_r[1];
        rd_d_r   <= rd_s_r[1];
    end
end

wire wr_rise = wr_s_r[1] & ~wr_d_r & ~cs_s_r[1];
wire rd_fall = ~rd_s_r[1] & rd_d_r & ~cs_s_r[1];

////////////////////////////////////////////////////////////////////////////////
// conversion clock: external pin or internal divider, one-cycle enables

reg [7:0] osc_cnt_r;
reg       osc_r;
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        osc_cnt_r <= 8'h00;
        osc_r     <= 1'b0;
    end else if (osc_cnt_r == OSC_DIV[7:0] - 8'h01) begin
        osc_cnt_r <= 8'h00;
        osc_r     <= ~osc_r;
    end else begin
        osc_cnt_r <= osc_cnt_r + 8'h01;
    end
end

reg  osc_prev_r;
always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        osc_prev_r <= 1'b0;
    end else begin
        osc_prev_r <= osc_r;
    end
end

// edges found per source, so switching the source cannot fake an edge
wire ext_clk_mode = power_mode[1] & power_mode[0];
wire ext_fall     = ~ck_s_r[1] & ck_d_r;
wire ext_rise     = ck_s_r[1] & ~ck_d_r;
wire osc_fall     = ~osc_r & osc_prev_r;
wire osc_rise     = osc_r & ~osc_prev_r;
// hold timing counts falling edges, approximation steps count rising edges
wire cclk_fall    = ext_clk_mode ? ext_fall : osc_fall;
wire cclk_rise    = ext_clk_mode ? ext_rise : osc_rise;

////////////////////////////////////////////////////////////////////////////////
// sequencer

localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_ACQ  = 4'h2;
localparam [3:0] ST_CONV = 4'h4;
localparam [3:0] ST_DONE = 4'h8;

reg [3:0]          state_r;
reg [7:0]          ctrl_r;
reg [2:0]          acq_cnt_r;
reg [3:0]          conv_cnt_r;
reg [RES_BITS-1:0] result_r;
reg [RES_BITS-1:0] bit_r;

wire new_ext = din_s2_r[`SATHS_CB_EXTACQ];

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        state_r    <= ST_IDLE;
        ctrl_r     <= `SATHS_CB_RESET;
        acq_cnt_r  <= 3'h0;
        conv_cnt_r <= 4'h0;
        result_r   <= {RES_BITS{1'b0}};
        bit_r      <= {RES_BITS{1'b0}};
        dac_code   <= {RES_BITS{1'b0}};
        eoc_n      <= 1'b1;
    end else if (wr_rise && state_r == ST_ACQ && ctrl_r[`SATHS_CB_EXTACQ] && !new_ext) begin
        // second write ends external acquisition; only the power bits and the external acquisition bit change
        ctrl_r[`SATHS_CB_PD1:`SATHS_CB_PD0] <= din_s2_r[`SATHS_CB_PD1:`SATHS_CB_PD0];
        ctrl_r[`SATHS_CB_EXTACQ] <= 1'b0;
        state_r    <= ST_CONV;                                   // see [RL2]
        conv_cnt_r <= 4'h0;
        bit_r      <= {1'b1, {(RES_BITS-1){1'b0}}};
        dac_code   <= {1'b1, {(RES_BITS-1){1'b0}}};
        eoc_n      <= 1'b1;
    end else if (wr_rise) begin
        // any other write latches the byte and restarts tracking, aborting a conversion
        ctrl_r    <= din_s2_r;                                   // see [RL14]
        state_r   <= ST_ACQ;                                     // see [RL1]
        acq_cnt_r <= 3'h0;
        eoc_n     <= 1'b1;
    end else begin
        case (state_r)
            ST_IDLE: begin
                state_r <= ST_IDLE;
            end
            ST_ACQ: begin
                if (!ctrl_r[`SATHS_CB_EXTACQ] && cclk_fall) begin
                    if (acq_cnt_r == `SATHS_ACQ_EDGES - 3'h1) begin
                        state_r    <= ST_CONV;                   // see [RL3] see [RL4]
                        conv_cnt_r <= 4'h0;
                        bit_r      <= {1'b1, {(RES_BITS-1){1'b0}}};
                        dac_code   <= {1'b1, {(RES_BITS-1){1'b0}}};
                    end else begin
                        acq_cnt_r <= acq_cnt_r + 3'h1;
                    end
                end
            end
            ST_CONV: begin
                if (cclk_rise) begin
                    conv_cnt_r <= conv_cnt_r + 4'h1;
                    // cycle 0 settles the capacitor swap, then one bit per cycle
                    if (conv_cnt_r >= 4'h1 && bit_r != {RES_BITS{1'b0}}) begin
                        // comparator crosses two sync stages: a conversion clock
                        // period under three system clocks would read a stale decision
                        // comparator high means trial code too large: drop bit
                        if (cmp_s_r[1]) begin                    // see [RL10]
                            dac_code <= (dac_code & ~bit_r) | (bit_r >> 1);
                        end else begin
                            dac_code <= dac_code | (bit_r >> 1);
                        end
                        bit_r <= bit_r >> 1;
                    end
                    if (conv_cnt_r == CONV_CYC[3:0] - 4'h1) begin
                        state_r  <= ST_DONE;                     // see [RL13]
                        result_r <= dac_code;
                        eoc_n    <= 1'b0;
                    end
                end
            end
            ST_DONE: begin
                if (rd_fall) eoc_n <= 1'b1;
            end
            default: state_r <= ST_IDLE;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// switch and multiplexer controls, registered so they are glitch free

wire       in_acq  = (state_r == ST_ACQ);
wire       in_conv = (state_r == ST_CONV);
wire [2:0] addr    = ctrl_r[`SATHS_CB_ADDR_HI:`SATHS_CB_ADDR_LO];

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        track          <= 1'b0;
        hold_capacitor <= 1'b0;
        pos_sw         <= 1'b0;
        neg_sw         <= 1'b0;
        pos_chan       <= 3'h0;
        neg_chan       <= 3'h0;
        neg_to_com     <= 1'b0;
        unipolar       <= 1'b0;
        power_mode     <= 2'h0;
    end else begin
        // after an abort, tracking waits until the negative switch has opened
        track          <= in_acq & ~neg_sw;                      // see [RL7] see [RL9]
        hold_capacitor <= ~(in_acq & ~neg_sw);                   // see [RL7]
        // a switch closes only once the other has been seen open
        pos_sw         <= in_acq & ~neg_sw;                      // see [RL16] see [RL9]
        neg_sw         <= in_conv & ~pos_sw;                     // see [RL8] see [RL16]
        // ctrl only changes on a write, so channels stay fixed to the end
        if (ctrl_r[`SATHS_CB_SGL]) begin
            pos_chan   <= addr;                                  // see [RL5] see [RL15]
            neg_chan   <= addr;
            neg_to_com <= 1'b1;
        end else begin
            pos_chan   <= {addr[2:1], addr[0]};                  // see [RL6] see [RL15]
            neg_chan   <= {addr[2:1], ~addr[0]};
            neg_to_com <= 1'b0;
        end
        unipolar       <= ctrl_r[`SATHS_CB_UNI];
        power_mode     <= ctrl_r[`SATHS_CB_PD1:`SATHS_CB_PD0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// result port: two msbs or eight lsbs, driven only while selected and reading

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        data_out <= 8'h00;
        data_oe  <= 1'b0;
    end else begin
        data_oe <= ~cs_s_r[1] & ~rd_s_r[1];                      // see [RL11]
        if (hb_s_r[1]) data_out <= {6'h00, result_r[RES_BITS-1:RES_BITS-2]}; // see [RL12]
        else data_out <= result_r[7:0];                          // see [RL12]
    end
end

endmodule
`default_nettype wire

/* File: bench/saths_sequencer_monitor.sv */
// assertion checker for the track/hold sequencer ports
`default_nettype none
module saths_sequencer_monitor (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       cs_n,
    input wire logic       wr_n,
    input wire logic       rd_n,
    input wire logic [7:0] data_in,
    input wire logic       eoc_n,
    input wire logic       track,
    input wire logic       hold_capacitor,
    input wire logic       pos_sw,
    input wire logic       neg_sw,
    input wire logic [2:0] pos_chan,
    input wire logic [2:0] neg_chan,
    input wire logic       neg_to_com
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////
    AST_NO_OVERLAP: assert property (!(pos_sw && neg_sw))
        else $error("switch overlap");
    AST_TRACK_START: assert property (
        $rose(wr_n) && !cs_n && data_in[5] |-> ##[2:6] track)
        else $error("no tracking after write");
    AST_EXT_HOLD: assert property (
        $rose(wr_n) && !cs_n && !data_in[5] && track |-> ##[2:8] !track)
        else $error("no hold after second write");
    AST_TRACK_POS: assert property (track |-> pos_sw && !hold_capacitor)
        else $error("tracking off positive input");
    AST_NEG_HELD: assert property (neg_sw |-> hold_capacitor && !track)
        else $error("negative switch while not held");
    AST_DIFF_PAIR: assert property (
        track && !neg_to_com |-> neg_chan == {pos_chan[2:1], ~pos_chan[0]})
        else $error("wrong channel pair");
    // cs_n high for a while means no write is being taken in the sync stages
    AST_CHAN_STABLE: assert property (
        neg_sw && cs_n && $past(cs_n, 4) |-> $stable(pos_chan))
        else $error("channel moved in conversion");
    AST_EOC_WRITE: assert property ($rose(wr_n) && !cs_n |-> ##[1:5] eoc_n)
        else $error("ready not cleared by write");
    AST_EOC_READ: assert property (
        !eoc_n && !cs_n && $fell(rd_n) |-> ##[1:5] eoc_n)
        else $error("ready not cleared by read");
endmodule
bind saths_sequencer saths_sequencer_monitor saths_sequencer_monitor_inst (.clock, .reset_n,
    .cs_n, .wr_n, .rd_n, .data_in, .eoc_n, .track, .hold_capacitor, .pos_sw, .neg_sw,
    .pos_chan, .neg_chan, .neg_to_com);
`default_nettype wire

/* File: bench/saths_analog_model.sv */
// comparator and sampled-input model facing the sequencer
`default_nettype none
module saths_analog_model (
    input  wire logic       clock,
    input  wire logic       track,
    input  wire logic [9:0] vin,
    input  wire logic [9:0] dac_code,
    output wire logic       comp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] held_r;
    // input moves after tracking ends must not reach the result
    always @(posedge clock) if (track) held_r <= vin;
    assign comp_out = dac_code > held_r;
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the track/hold sequencer
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, reset_n = 0, cs_n = 1, wr_n = 1, rd_n = 1, hbs = 0, conv_clk = 0;
    logic [7:0] data_in = 8'h00, data_out, lo, hi;
    logic [9:0] vin = 10'h000, dac_code;
    logic [15:0] rnd = 16'h6426;
    logic data_oe, eoc_n, track, hold_cap, pos_sw, neg_sw, neg_to_com, unipolar, comp_out;
    logic [2:0] pos_chan, neg_chan;
    logic [1:0] power_mode;
    int n_mismatch = 0, check_count = 0;
    always #2.5 clock = ~clock;
    // both conversion clocks keep a half period of at least three system clocks
    always #20 conv_clk = ~conv_clk;
    saths_sequencer #(.OSC_DIV(3)) saths_sequencer_inst (.clock, .reset_n, .cs_n, .wr_n,
        .rd_n, .high_byte_select(hbs), .conv_clk, .data_in, .comp_out, .data_out, .data_oe,
        .eoc_n, .track, .hold_capacitor(hold_cap), .pos_sw, .neg_sw, .pos_chan, .neg_chan,
        .neg_to_com, .unipolar, .dac_code, .power_mode);
    saths_analog_model saths_analog_model_inst (.clock, .track, .vin, .dac_code, .comp_out);
    ////////////////////////////////////////////////////////////////////////////
    function automatic [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic [2:0] pair_of(input [2:0] a);
        pair_of = {a[2:1], ~a[0]};
    endfunction
    task automatic chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wr(input [7:0] b);
        cs_n = 0;
        data_in = b;
        tick(3);
        wr_n = 0;
        tick(3);
        wr_n = 1;
        tick(5);
        cs_n = 1;
        chk(pos_chan, b[2:0]);
        chk(neg_to_com, b[4]);
        if (!b[4]) chk(neg_chan, pair_of(b[2:0]));
        chk({power_mode, unipolar}, {b[7:6], b[3]});
    endtask
    task automatic rd(input logic hb, output [7:0] v);
        hbs = hb;
        cs_n = 0;
        rd_n = 0;
        tick(6);
        chk(data_oe, 1'b1);
        v = data_out;
        rd_n = 1;
        cs_n = 1;
        tick(3);
        chk(data_oe, 1'b0);
    endtask
    task automatic conv(input [7:0] b, input [9:0] v);
        vin = v;
        wr(b);
        // bounded wait: a lost conversion is counted as a mismatch instead of hanging the run
        for (int i = 0; i < 400 && eoc_n !== 1'b0; i++) tick(1);
        if (eoc_n !== 1'b0) begin
            // counted here; the run still closes through wrap_up at the end
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, eoc_n, 1'b0);
        end else begin
            rd(0, lo);
            rd(1, hi);
            chk({hi[1:0], lo}, v);
            chk(hi[7:2], 6'h00);
            chk(eoc_n, 1'b1);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(6);
        reset_n = 1;
        chk({eoc_n, track}, 2'b10);
        tick(2);
        conv(8'h9f, 10'h3ff);
        conv(8'hc0, 10'h000);
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            conv({1'b1, rnd[0], 1'b0, rnd[5:1]}, rnd[15:6]);
        end
        $display("test conversions done");
        vin = 10'h2a5;
        wr(8'hb3);
        tick(20);
        chk(track, 1'b1);
        conv(8'h93, 10'h2a5);
        $display("test external acquisition done");
        vin = 10'h0f0;
        wr(8'h81);
        // long enough to be past the hold point and inside the conversion
        tick(40);
        chk(eoc_n, 1'b1);
        chk({hold_cap, track}, 2'b10);
        conv(8'h81, 10'h30c);
        $display("test abort done");
        wrap_up();
    end
endmodule
`default_nettype wire
